// File: swd_safety_watchdog.v
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "swd_safety_watchdog_regs.vh"
module swd_safety_watchdog (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    input  wire        slow_rc_clk_i,
    input  wire        main_rc_div_clk_i,
    input  wire        main_rc_enabled_i,
    input  wire        primary_uses_slow_rc_i,
    input  wire        debug_state_i,
    input  wire        idle_mode_i,
    output reg         fault_o,
    output reg         fault_all_resets_o,
    output reg         fault_proc_reset_o,
    output reg         irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg  [1:0]  slow_sync_r;
reg  [1:0]  main_sync_r;
reg  [1:0]  sel_sync_r;
reg  [1:0]  dbg_sync_r;
reg  [1:0]  idle_sync_r;
reg         tick_src_prev_r;

wire        use_main_w = sel_sync_r[1];
wire        src_lvl_w  = use_main_w ? main_sync_r[1] : slow_sync_r[1];
wire        slow_tick_w = src_lvl_w & ~tick_src_prev_r;

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        slow_sync_r     <= 2'h0;
        main_sync_r     <= 2'h0;
        sel_sync_r      <= 2'h0;
        dbg_sync_r      <= 2'h0;
        idle_sync_r     <= 2'h0;
        tick_src_prev_r <= 1'b0;
    end else begin
        slow_sync_r     <= {slow_sync_r[0], slow_rc_clk_i};
        main_sync_r     <= {main_sync_r[0], main_rc_div_clk_i};
        sel_sync_r      <= {sel_sync_r[0], main_rc_enabled_i | primary_uses_slow_rc_i};
        dbg_sync_r      <= {dbg_sync_r[0], debug_state_i};
        idle_sync_r     <= {idle_sync_r[0], idle_mode_i};
        tick_src_prev_r <= src_lvl_w;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register bus
reg  [31:0] cfg_r;
reg         cfg_locked_r;
reg         ack_r;
reg  [11:0] cnt_r;
reg  [6:0]  pre_r;
reg         unf_r;
reg         err_r;

wire        req_w      = (avs_read_i | avs_write_i) & ~ack_r;
wire        wr_w       = avs_write_i & ~ack_r;
wire        rd_w       = avs_read_i & ~ack_r;
wire        cmd_hit_w  = wr_w & (avs_address_i == `SWD_OFF_CMD) & (&avs_byteenable_i);
wire        key_ok_w   = avs_writedata_i[`SWD_KEY_HI:`SWD_KEY_LO] == `SWD_PASSWORD;
wire        restart_w  = cmd_hit_w & key_ok_w & avs_writedata_i[`SWD_RESTART_BIT];
wire        cfg_wr_w   = wr_w & (avs_address_i == `SWD_OFF_CFG) & ~cfg_locked_r;
wire        flags_rd_w = rd_w & (avs_address_i == `SWD_OFF_FLAGS);

wire [11:0] reload_w   = cfg_r[`SWD_RV_HI:`SWD_RV_LO];
wire [11:0] delta_w    = cfg_r[`SWD_WD_HI:`SWD_WD_LO];
wire        off_w      = cfg_r[`SWD_OFF_BIT];
wire        win_err_w  = restart_w & (delta_w < reload_w) & (cnt_r > delta_w);

reg  [31:0] cfg_byte_w;
reg  [31:0] rdata_nxt;
integer     bi;

always @* begin
    cfg_byte_w = cfg_r;
    for (bi = 0; bi < 4; bi = bi + 1) begin
        if (avs_byteenable_i[bi]) begin
            cfg_byte_w[bi*8 +: 8] = avs_writedata_i[bi*8 +: 8];
        end
    end
    cfg_byte_w = cfg_byte_w & `SWD_CFG_WMASK;
end

always @* begin
    case (avs_address_i)
        `SWD_OFF_CFG:   rdata_nxt = cfg_r;
        `SWD_OFF_FLAGS: rdata_nxt = {30'h00000000, err_r, unf_r};
        default:        rdata_nxt = 32'h00000000;
    endcase
end

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        ack_r             <= 1'b0;
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o    <= 32'h00000000;
        cfg_r             <= `SWD_CFG_RESET;
        cfg_locked_r      <= 1'b0;
    end else begin
        ack_r             <= req_w;
        avs_waitrequest_o <= ~req_w;
        if (rd_w) begin
            avs_readdata_o <= rdata_nxt;
        end
        if (cfg_wr_w) begin
            cfg_r        <= cfg_byte_w;
            cfg_locked_r <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Prescaler and counter
wire        halted_w   = off_w | (cfg_r[`SWD_DBG_BIT] & dbg_sync_r[1])
                       | (cfg_r[`SWD_IDLE_BIT] & idle_sync_r[1]);
wire        pre_tick_w = slow_tick_w & ~halted_w & (pre_r == `SWD_PRESCALE_MAX);
wire        underflow_w = pre_tick_w & (cnt_r == `SWD_CNT_ZERO);

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        pre_r <= `SWD_PRE_ZERO;
        cnt_r <= `SWD_CNT_ZERO;
    end else if (cfg_wr_w) begin
        pre_r <= `SWD_PRE_ZERO;
        cnt_r <= cfg_byte_w[`SWD_RV_HI:`SWD_RV_LO];
    end else if (restart_w & ~win_err_w) begin
        pre_r <= `SWD_PRE_ZERO;
        cnt_r <= reload_w;
    end else if (slow_tick_w & ~halted_w) begin
        pre_r <= pre_r + `SWD_PRE_ONE;
        if (pre_tick_w) begin
            cnt_r <= underflow_w ? reload_w : cnt_r - `SWD_CNT_ONE;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status flags and fault outputs
wire        unf_nxt = underflow_w | (unf_r & ~flags_rd_w);
wire        err_nxt = win_err_w | (err_r & ~flags_rd_w);
wire        any_nxt = unf_nxt | err_nxt;
wire        rst_en_w = cfg_r[`SWD_RSTEN_BIT];

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        unf_r              <= 1'b0;
        err_r              <= 1'b0;
        fault_o            <= 1'b0;
        fault_all_resets_o <= 1'b0;
        fault_proc_reset_o <= 1'b0;
        irq_o              <= 1'b0;
    end else begin
        unf_r              <= unf_nxt;
        err_r              <= err_nxt;
        fault_o            <= (unf_nxt & rst_en_w) | err_nxt;
        fault_all_resets_o <= any_nxt & rst_en_w & ~cfg_r[`SWD_PROC_BIT];
        fault_proc_reset_o <= any_nxt & rst_en_w & cfg_r[`SWD_PROC_BIT];
        irq_o              <= any_nxt & cfg_r[`SWD_FIEN_BIT];
    end
end

endmodule // swd_safety_watchdog

// File: swd_safety_watchdog_regs.vh
// Functional notes
// - 12-bit down counter, slow clock over 128
// - Reload value resets to 0xFFF
// - Comes up disabled, mode register defaulted
// - Mode register writable once per reset
// - Mode write reloads counter and restarts
// - Full-word key 0xC4 with restart bit reloads counter unless window error
// - Wrong key write is discarded
// - Underflow sets flag, fault if reset enabled
// - Restart above delta sets error and fault
// - Delta at or above reload disables window
// - Interrupt on flags when irq enabled
// - Processor-only bit selects reset scope
// - Status read clears flags, irq, fault
// - Watchdog reset clears both flags
// - Flags sticky until status read
// - Debug halt stops counter in debug
// - Idle halt stops counter in idle
// - Main RC clock selected when main RC enabled or primary uses slow RC
`ifndef SWD_SAFETY_WATCHDOG_REGS_VH
`define SWD_SAFETY_WATCHDOG_REGS_VH
`define SWD_ADDR_W          4
`define SWD_OFF_CMD         4'h0
`define SWD_OFF_CFG         4'h4
`define SWD_OFF_FLAGS       4'h8
`define SWD_CFG_RESET       32'h3FFFAFFF
`define SWD_CFG_WMASK       32'h3FFFFFFF
`define SWD_KEY_HI          31
`define SWD_KEY_LO          24
`define SWD_PASSWORD        8'hC4
`define SWD_RESTART_BIT     0
`define SWD_RV_HI           11
`define SWD_RV_LO           0
`define SWD_FIEN_BIT        12
`define SWD_RSTEN_BIT       13
`define SWD_PROC_BIT        14
`define SWD_OFF_BIT         15
`define SWD_WD_HI           27
`define SWD_WD_LO           16
`define SWD_DBG_BIT         28
`define SWD_IDLE_BIT        29
`define SWD_PRESCALE_MAX    7'h7F
`define SWD_CNT_ZERO        12'h000
`define SWD_CNT_ONE         12'h001
`define SWD_PRE_ZERO        7'h00
`define SWD_PRE_ONE         7'h01
`endif

// File: swd_checker.sv
`timescale 1ns/1ps
module swd_checker (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        fault_o,
    input wire logic        fault_all_resets_o,
    input wire logic        fault_proc_reset_o,
    input wire logic        irq_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_b_i);
sequence s_rd; avs_read_i && avs_address_i == 4'h8 && avs_waitrequest_o ##1 !avs_waitrequest_o; endsequence
sequence s_key; avs_write_i && avs_address_i == 4'h0 && avs_writedata_i[31:24] != 8'hC4 && !fault_o; endsequence
property p_clr; s_rd |=> !fault_o && !irq_o && !fault_all_resets_o && !fault_proc_reset_o; endproperty
property p_key; s_key |=> ##1 !fault_o; endproperty
property p_excl; !(fault_all_resets_o && fault_proc_reset_o); endproperty
property p_scope; fault_all_resets_o || fault_proc_reset_o |-> fault_o; endproperty
property p_fhold; fault_o && !(avs_read_i && avs_address_i == 4'h8) |=> fault_o; endproperty
property p_ihold; irq_o && !(avs_read_i && avs_address_i == 4'h8) |=> irq_o; endproperty
property p_quiet; $rose(rst_b_i) |-> avs_waitrequest_o && !fault_o && !irq_o; endproperty
property p_wait; $fell(avs_waitrequest_o) |=> avs_waitrequest_o; endproperty
a_clr: assert property (p_clr) else $error("read kept fault");
a_key: assert property (p_key) else $error("bad key acted");
a_excl: assert property (p_excl) else $error("scope clash");
a_scope: assert property (p_scope) else $error("scope no fault");
a_fhold: assert property (p_fhold) else $error("fault dropped");
a_ihold: assert property (p_ihold) else $error("irq dropped");
a_quiet: assert property (p_quiet) else $error("reset not quiet");
a_wait: assert property (p_wait) else $error("wait low too long");
endmodule // swd_checker
bind swd_safety_watchdog swd_checker swd_checker_inst (.clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_waitrequest_o, .fault_o, .fault_all_resets_o, .fault_proc_reset_o, .irq_o);

// File: swd_partner.sv
`timescale 1ns/1ps
module swd_partner (
    input  wire logic clk_i,
    output wire logic slow_rc_clk_o,
    output wire logic main_rc_div_clk_o
);
logic [3:0] div_r = 4'h0;
always @(posedge clk_i) div_r <= div_r + 4'h1;
assign slow_rc_clk_o = div_r[3];
assign main_rc_div_clk_o = div_r[2];
endmodule // swd_partner

// File: tb.sv
`timescale 1ns/1ps
module tb;
logic clk_i = 1'h0, rst_b_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0, slow_rc_clk_i, main_rc_div_clk_i;
logic main_rc_enabled_i = 1'h0, primary_uses_slow_rc_i = 1'h0, debug_state_i = 1'h0, idle_mode_i = 1'h0;
logic avs_waitrequest_o, fault_o, fault_all_resets_o, fault_proc_reset_o, irq_o;
logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
logic [35:0] rows [3] = '{{4'h4, 32'h3FFFAFFF}, {4'h8, 32'h0}, {4'hC, 32'h0}};
int errors = 0, checks_done = 0, n;
swd_safety_watchdog swd_safety_watchdog_inst (.clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .slow_rc_clk_i, .main_rc_div_clk_i,
    .main_rc_enabled_i, .primary_uses_slow_rc_i, .debug_state_i, .idle_mode_i, .fault_o, .fault_all_resets_o,
    .fault_proc_reset_o, .irq_o);
swd_partner swd_partner_inst (.clk_i, .slow_rc_clk_o(slow_rc_clk_i), .main_rc_div_clk_o(main_rc_div_clk_i));
////////////////////////////////////////////////////////////////
task automatic conclude;
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
        errors++;
        $display("mismatch %s expected %h seen %h", nm, e, s);
    end
endtask
task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin
        @(posedge clk_i);
        n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    if (n >= 50) check("wait", 32'h1, 32'h0);
    @(posedge clk_i);
endtask
task automatic do_reset;
    rst_b_i <= 1'h0;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'h1;
    @(posedge clk_i);
endtask
////////////////////////////////////////////////////////////////
initial forever #25 clk_i = ~clk_i;
initial begin
    do_reset();
    foreach (rows[i]) begin
        bus(1'h0, rows[i][35:32], 32'h0);
        check("read", rd, rows[i][31:0]);
    end
    // Reload 3, irq and all-resets on, window off
    bus(1'h1, 4'h4, 32'h0FFF3003);
    bus(1'h1, 4'h4, 32'h3FFFAFFF);
    bus(1'h0, 4'h4, 32'h0);
    check("cfg", rd, 32'h0FFF3003);
    bus(1'h1, 4'h0, 32'hA5000001);
    bus(1'h1, 4'h0, 32'hC4000001);
    repeat (2) @(posedge clk_i);
    check("no err", fault_o, 32'h0);
    n = 0;
    while (irq_o !== 1'h1 && n < 20000) begin
        @(posedge clk_i);
        n++;
    end
    if (n >= 20000) check("timeout", 32'h1, 32'h0);
    check("unf out", {fault_o, fault_all_resets_o, fault_proc_reset_o, irq_o}, 32'hD);
    bus(1'h0, 4'h8, 32'h0);
    check("unf flag", rd, 32'h1);
    repeat (2) @(posedge clk_i);
    check("clr", {fault_o, irq_o}, 32'h0);
    do_reset();
    // Reload 0xFF, delta 0, processor-only reset
    bus(1'h1, 4'h4, 32'h000060FF);
    repeat (60) @(posedge clk_i);
    bus(1'h1, 4'h0, 32'hC4000001);
    repeat (2) @(posedge clk_i);
    check("err out", {fault_o, fault_all_resets_o, fault_proc_reset_o, irq_o}, 32'hA);
    bus(1'h0, 4'h8, 32'h0);
    check("err flag", rd, 32'h2);
    // Reload 0, both halts, main RC clock selected
    do_reset();
    debug_state_i <= 1'h1;
    main_rc_enabled_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    bus(1'h1, 4'h4, 32'h3FFF1000);
    repeat (1500) @(posedge clk_i);
    check("dbg halt", irq_o, 32'h0);
    debug_state_i <= 1'h0;
    idle_mode_i <= 1'h1;
    repeat (1500) @(posedge clk_i);
    check("idle halt", irq_o, 32'h0);
    idle_mode_i <= 1'h0;
    n = 0;
    while (irq_o !== 1'h1 && n < 1200) begin
        @(posedge clk_i);
        n++;
    end
    check("main clk", n < 1200, 32'h1);
    bus(1'h0, 4'h8, 32'h0);
    check("halt unf", rd, 32'h1);
    conclude();
end
endmodule // tb
